// ==== rtl/alu_pkg.sv ====
// Constants for the eight-bit arithmetic and logic datapath
`default_nettype none
package alu_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_OPA = 8'h04;
    localparam logic [7:0] ADDR_OPB = 8'h08;
    localparam logic [7:0] ADDR_PAIR = 8'h0C;
    localparam logic [7:0] ADDR_RESULT = 8'h10;
    localparam logic [7:0] ADDR_PRODUCT = 8'h14;
    localparam logic [7:0] ADDR_FLAGS = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1C;
    // ==========================================================
    // Register select codes
    localparam logic [3:0] SEL_CTRL = 4'h0;
    localparam logic [3:0] SEL_OPA = 4'h1;
    localparam logic [3:0] SEL_OPB = 4'h2;
    localparam logic [3:0] SEL_PAIR = 4'h3;
    localparam logic [3:0] SEL_RESULT = 4'h4;
    localparam logic [3:0] SEL_PRODUCT = 4'h5;
    localparam logic [3:0] SEL_FLAGS = 4'h6;
    localparam logic [3:0] SEL_STATUS = 4'h7;
    localparam logic [3:0] SEL_NONE = 4'hF;
    // ==========================================================
    // Operation codes
    localparam logic [4:0] OP_ADD = 5'h00;
    localparam logic [4:0] OP_ADC = 5'h01;
    localparam logic [4:0] OP_PAIR_SUM = 5'h02;
    localparam logic [4:0] OP_SUB = 5'h03;
    localparam logic [4:0] OP_SUB_CARRY = 5'h04;
    localparam logic [4:0] OP_SUB_K = 5'h05;
    localparam logic [4:0] OP_SUB_CARRY_K = 5'h06;
    localparam logic [4:0] OP_PAIR_DIFF = 5'h07;
    localparam logic [4:0] OP_AND = 5'h08;
    localparam logic [4:0] OP_AND_K = 5'h09;
    localparam logic [4:0] OP_OR = 5'h0A;
    localparam logic [4:0] OP_OR_K = 5'h0B;
    localparam logic [4:0] OP_XOR = 5'h0C;
    localparam logic [4:0] OP_SET_MASK = 5'h0D;
    localparam logic [4:0] OP_CLR_MASK = 5'h0E;
    localparam logic [4:0] OP_TEST = 5'h0F;
    localparam logic [4:0] OP_PROD_U = 5'h10;
    localparam logic [4:0] OP_PROD_S = 5'h11;
    localparam logic [4:0] OP_PROD_SU = 5'h12;
    localparam logic [4:0] OP_FRAC_U = 5'h13;
    localparam logic [4:0] OP_FRAC_S = 5'h14;
    localparam logic [4:0] OP_FRAC_SU = 5'h15;
    localparam logic [4:0] OP_LAST = 5'h15;
    // ==========================================================
    // Flag bit positions and reset values
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [5:0] FLAGS_RESET = 6'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam int STATUS_BUSY = 0;
    // ==========================================================
    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_FINAL = 3'b100
    } state_t;
endpackage : alu_pkg
`default_nettype wire

// ==== rtl/alu_datapath.sv ====
// Eight-bit arithmetic and logic datapath with APB register access
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Add and add-with-carry of two bytes write the destination, set Z C N V H, one cycle.
// - Pair add of a constant writes the 16-bit pair, sets Z C N V S, two cycles.
// - Register subtract, optionally with carry, writes the destination, sets Z C N V H, one cycle.
// - Constant subtract, optionally with carry, sets Z C N V H in one cycle.
// - Pair subtract of a constant writes the pair back, sets Z C N V S, two cycles.
// - AND and OR with register or constant, and XOR with register, write the result and set only Z N V, one cycle.
// - Bit-set ORs a mask in, bit-clear ANDs with all-ones minus the mask, Z N V, one cycle.
// - The zero-or-minus test ANDs a byte with itself and sets only Z N V, one cycle.
// - Plain multiplies put the 16-bit product in the product register, set Z C, two cycles.
// - Fractional multiplies shift the product left one bit first, set Z C, two cycles.
module alu_datapath (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import alu_pkg::*;

    // ==========================================================
    // Decoding helpers
    function automatic logic [3:0] reg_sel(input logic [7:0] addr);
        unique case (addr)
            ADDR_CTRL: reg_sel = SEL_CTRL;
            ADDR_OPA: reg_sel = SEL_OPA;
            ADDR_OPB: reg_sel = SEL_OPB;
            ADDR_PAIR: reg_sel = SEL_PAIR;
            ADDR_RESULT: reg_sel = SEL_RESULT;
            ADDR_PRODUCT: reg_sel = SEL_PRODUCT;
            ADDR_FLAGS: reg_sel = SEL_FLAGS;
            ADDR_STATUS: reg_sel = SEL_STATUS;
            default: reg_sel = SEL_NONE;
        endcase
    endfunction : reg_sel

    function automatic logic two_cycle(input logic [4:0] op);
        two_cycle = (op == OP_PAIR_SUM) || (op == OP_PAIR_DIFF) || (op >= OP_PROD_U);
    endfunction : two_cycle

    // ==========================================================
    // State
    state_t state_reg, state_next;
    logic [4:0] op_reg, op_next;
    logic [7:0] opa_reg, opa_next;
    logic [7:0] opb_reg, opb_next;
    logic [15:0] pair_reg, pair_next;
    logic [7:0] result_reg, result_next;
    logic [15:0] product_reg, product_next;
    logic [5:0] flags_reg, flags_next;
    logic [7:0] done_count_reg, done_count_next;
    logic accept_reg, accept_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;

    logic [3:0] sel;
    logic wr_take;
    logic start;
    logic commit;
    logic carry_in;
    logic [8:0] sum9;
    logic [8:0] diff9;
    logic [15:0] word_sum;
    logic [15:0] word_diff;
    logic signed_a;
    logic signed_b;
    logic frac;
    logic [15:0] ext_a;
    logic [15:0] ext_b;
    logic [31:0] prod32;
    logic [15:0] raw_prod;
    logic [15:0] prod_out;
    logic [7:0] logic_res;

    // ==========================================================
    // Operand arithmetic
    assign sel = reg_sel(paddr);
    assign wr_take = psel && penable && pready_reg && pwrite && accept_reg;
    assign start = wr_take && (sel == SEL_CTRL);
    assign carry_in = ((op_reg == OP_ADC) || (op_reg == OP_SUB_CARRY)
        || (op_reg == OP_SUB_CARRY_K))
        && flags_reg[FLAG_C];
    assign sum9 = {1'b0, opa_reg} + {1'b0, opb_reg} + {8'h00, carry_in};
    assign diff9 = {1'b0, opa_reg} - {1'b0, opb_reg} - {8'h00, carry_in};
    assign word_sum = pair_reg + {8'h00, opb_reg};
    assign word_diff = pair_reg - {8'h00, opb_reg};
    assign signed_a = (op_reg == OP_PROD_S) || (op_reg == OP_PROD_SU)
        || (op_reg == OP_FRAC_S) || (op_reg == OP_FRAC_SU);
    assign signed_b = (op_reg == OP_PROD_S) || (op_reg == OP_FRAC_S);
    assign frac = (op_reg >= OP_FRAC_U);
    assign ext_a = signed_a ? {{8{opa_reg[7]}}, opa_reg} : {8'h00, opa_reg};
    assign ext_b = signed_b ? {{8{opb_reg[7]}}, opb_reg} : {8'h00, opb_reg};
    assign prod32 = ext_a * ext_b;
    assign raw_prod = prod32[15:0];
    assign prod_out = frac ? {raw_prod[14:0], 1'b0} : raw_prod;

    // ==========================================================
    // Logic unit
    always_comb begin
        unique case (op_reg)
            OP_AND, OP_AND_K: logic_res = opa_reg & opb_reg;
            OP_OR, OP_OR_K, OP_SET_MASK: logic_res = opa_reg | opb_reg;
            OP_XOR: logic_res = opa_reg ^ opb_reg;
            OP_CLR_MASK: logic_res = opa_reg & (ALL_ONES - opb_reg);
            default: logic_res = opa_reg & opa_reg;
        endcase
    end

    // ==========================================================
    // Sequencer, operand registers and flags
    always_comb begin
        state_next = state_reg;
        op_next = op_reg;
        opa_next = opa_reg;
        opb_next = opb_reg;
        pair_next = pair_reg;
        result_next = result_reg;
        product_next = product_reg;
        flags_next = flags_reg;
        done_count_next = done_count_reg;
        commit = 1'b0;
        unique case (state_reg)
            ST_IDLE: begin
                if (start) begin
                    op_next = pwdata[4:0];
                    state_next = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (two_cycle(op_reg)) begin
                    state_next = ST_FINAL;
                end else begin
                    commit = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            ST_FINAL: begin
                commit = 1'b1;
                state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
        if (wr_take) begin
            unique case (sel)
                SEL_OPA: opa_next = pwdata[7:0];
                SEL_OPB: opb_next = pwdata[7:0];
                SEL_PAIR: pair_next = pwdata[15:0];
                SEL_FLAGS: flags_next = pwdata[5:0];
                default: ;
            endcase
        end
        if (commit) begin
            done_count_next = done_count_reg + 8'h01;
            unique case (op_reg)
                OP_ADD, OP_ADC: begin
                    opa_next = sum9[7:0];
                    result_next = sum9[7:0];
                    flags_next[FLAG_C] = sum9[8];
                    flags_next[FLAG_Z] = (sum9[7:0] == BYTE_RESET);
                    flags_next[FLAG_N] = sum9[7];
                    flags_next[FLAG_V] = (opa_reg[7] & opb_reg[7] & ~sum9[7])
                        | (~opa_reg[7] & ~opb_reg[7] & sum9[7]);
                    flags_next[FLAG_H] = (opa_reg[3] & opb_reg[3]) | (opb_reg[3] & ~sum9[3])
                        | (~sum9[3] & opa_reg[3]);
                end
                OP_SUB, OP_SUB_CARRY, OP_SUB_K, OP_SUB_CARRY_K: begin
                    opa_next = diff9[7:0];
                    result_next = diff9[7:0];
                    flags_next[FLAG_C] = diff9[8];
                    flags_next[FLAG_Z] = (diff9[7:0] == BYTE_RESET);
                    flags_next[FLAG_N] = diff9[7];
                    flags_next[FLAG_V] = (opa_reg[7] & ~opb_reg[7] & ~diff9[7])
                        | (~opa_reg[7] & opb_reg[7] & diff9[7]);
                    flags_next[FLAG_H] = (~opa_reg[3] & opb_reg[3]) | (opb_reg[3] & diff9[3])
                        | (diff9[3] & ~opa_reg[3]);
                end
                OP_PAIR_SUM: begin
                    pair_next = word_sum;
                    flags_next[FLAG_C] = ~word_sum[15] & pair_reg[15];
                    flags_next[FLAG_Z] = (word_sum == WORD_RESET);
                    flags_next[FLAG_N] = word_sum[15];
                    flags_next[FLAG_V] = ~pair_reg[15] & word_sum[15];
                    flags_next[FLAG_S] = word_sum[15] ^ (~pair_reg[15] & word_sum[15]);
                end
                OP_PAIR_DIFF: begin
                    pair_next = word_diff;
                    flags_next[FLAG_C] = word_diff[15] & ~pair_reg[15];
                    flags_next[FLAG_Z] = (word_diff == WORD_RESET);
                    flags_next[FLAG_N] = word_diff[15];
                    flags_next[FLAG_V] = pair_reg[15] & ~word_diff[15];
                    flags_next[FLAG_S] = word_diff[15] ^ (pair_reg[15] & ~word_diff[15]);
                end
                OP_PROD_U, OP_PROD_S, OP_PROD_SU, OP_FRAC_U, OP_FRAC_S, OP_FRAC_SU: begin
                    product_next = prod_out;
                    flags_next[FLAG_C] = raw_prod[15];
                    flags_next[FLAG_Z] = (prod_out == WORD_RESET);
                end
                default: begin
                    if (op_reg != OP_TEST) begin
                        opa_next = logic_res;
                    end
                    result_next = logic_res;
                    flags_next[FLAG_Z] = (logic_res == BYTE_RESET);
                    flags_next[FLAG_N] = logic_res[7];
                    flags_next[FLAG_V] = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            op_reg <= OP_ADD;
            opa_reg <= BYTE_RESET;
            opb_reg <= BYTE_RESET;
            pair_reg <= WORD_RESET;
            result_reg <= BYTE_RESET;
            product_reg <= WORD_RESET;
            flags_reg <= FLAGS_RESET;
            done_count_reg <= BYTE_RESET;
        end else begin
            state_reg <= state_next;
            op_reg <= op_next;
            opa_reg <= opa_next;
            opb_reg <= opb_next;
            pair_reg <= pair_next;
            result_reg <= result_next;
            product_reg <= product_next;
            flags_reg <= flags_next;
            done_count_reg <= done_count_next;
        end
    end

    // ==========================================================
    // APB response
    always_comb begin
        pready_next = psel && penable && !pready_reg;
        prdata_next = 32'h0000_0000;
        pslverr_next = 1'b0;
        accept_next = 1'b0;
        if (pready_next) begin
            if (sel == SEL_NONE) begin
                pslverr_next = 1'b1;
            end else if (pwrite) begin
                if (state_reg != ST_IDLE) begin
                    pslverr_next = 1'b1;
                end else if ((sel == SEL_CTRL) && (pwdata[4:0] > OP_LAST)) begin
                    pslverr_next = 1'b1;
                end else begin
                    accept_next = 1'b1;
                end
            end else begin
                unique case (sel)
                    SEL_CTRL: prdata_next = {27'h0000000, op_reg};
                    SEL_OPA: prdata_next = {24'h000000, opa_reg};
                    SEL_OPB: prdata_next = {24'h000000, opb_reg};
                    SEL_PAIR: prdata_next = {16'h0000, pair_reg};
                    SEL_RESULT: prdata_next = {24'h000000, result_reg};
                    SEL_PRODUCT: prdata_next = {16'h0000, product_reg};
                    SEL_FLAGS: prdata_next = {26'h0000000, flags_reg};
                    default: prdata_next = {16'h0000, done_count_reg, 7'h00,
                        (state_reg != ST_IDLE)};
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
            accept_reg <= 1'b0;
        end else begin
            pready_reg <= pready_next;
            prdata_reg <= prdata_next;
            pslverr_reg <= pslverr_next;
            accept_reg <= accept_next;
        end
    end

    assign pready = pready_reg;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence seq_start_single;
        start && (state_reg == ST_IDLE) && !two_cycle(pwdata[4:0]) && (pwdata[4:0] <= OP_LAST);
    endsequence
    sequence seq_start_double;
        start && (state_reg == ST_IDLE) && two_cycle(pwdata[4:0]);
    endsequence
    sequence seq_double_finish;
        !commit ##1 commit;
    endsequence

    chk_single_cycle_commit: assert property (seq_start_single |=> commit)
        else $error("single cycle operation did not commit next cycle");
    chk_double_cycle_commit: assert property (seq_start_double |=> seq_double_finish)
        else $error("two cycle operation did not commit on second cycle");
    chk_add_sum_value: assert property (commit && op_reg == OP_ADD |=>
        result_reg == 8'($past(opa_reg) + $past(opb_reg)))
        else $error("add result wrong");
    chk_pair_sum_value: assert property (commit && op_reg == OP_PAIR_SUM |=>
        pair_reg == 16'($past(pair_reg) + {8'h00, $past(opb_reg)}))
        else $error("pair add result wrong");
    chk_sub_borrow_flag: assert property (commit && op_reg == OP_SUB |=>
        flags_reg[FLAG_C] == ($past(opb_reg) > $past(opa_reg)))
        else $error("subtract carry wrong");
    chk_subk_value: assert property (commit && op_reg == OP_SUB_K |=>
        opa_reg == 8'($past(opa_reg) - $past(opb_reg)))
        else $error("constant subtract result wrong");
    chk_pair_diff_value: assert property (commit && op_reg == OP_PAIR_DIFF |=>
        pair_reg == 16'($past(pair_reg) - {8'h00, $past(opb_reg)}))
        else $error("pair subtract result wrong");
    chk_logic_flags_only: assert property (commit && op_reg >= OP_AND && op_reg <= OP_TEST |=>
        !flags_reg[FLAG_V] && $stable(flags_reg[FLAG_C]) && $stable(flags_reg[FLAG_H]))
        else $error("logic operation touched wrong flags");
    chk_clear_mask_value: assert property (commit && op_reg == OP_CLR_MASK |=>
        result_reg == ($past(opa_reg) & ~$past(opb_reg)))
        else $error("bit clear result wrong");
    chk_test_keeps_operand: assert property (commit && op_reg == OP_TEST |=>
        $stable(opa_reg) && flags_reg[FLAG_Z] == ($past(opa_reg) == BYTE_RESET))
        else $error("test operation wrong");
    chk_unsigned_product_value: assert property (commit && op_reg == OP_PROD_U |=>
        product_reg == 16'({8'h00, $past(opa_reg)} * {8'h00, $past(opb_reg)}))
        else $error("unsigned product wrong");
    chk_frac_shift_value: assert property (commit && op_reg == OP_FRAC_U |=>
        product_reg == 16'({8'h00, $past(opa_reg)} * {8'h00, $past(opb_reg)} * 16'h0002))
        else $error("fractional product wrong");
    chk_flags_held_idle: assert property (!commit && !(wr_take && sel == SEL_FLAGS) |=>
        $stable(flags_reg))
        else $error("flags changed without an operation");
endmodule : alu_datapath

`default_nettype wire

// ==== test/alu_host_model.sv ====
// APB master model standing in for the decoder and register file
`timescale 1ns/1ps
`default_nettype none
module alu_host_model (
    // Clock
    input wire logic pclk,
    // APB master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
    end
    // ==========================================================
    // One transfer, held until pready is sampled high
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines do not keep the last value
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : alu_host_model
`default_nettype wire

// ==== test/tb_eight_bit_alu_datapath.sv ====
// Self-checking bench for the eight-bit arithmetic and logic datapath
`timescale 1ns/1ps
`default_nettype none
module tb_eight_bit_alu_datapath;
    import alu_pkg::*;
    logic pclk;
    logic presetn;
    logic psel, penable, pwrite, pready, pslverr, last_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, v;
    int mismatches;
    int tests_run;
    alu_datapath i_alu_datapath (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    alu_host_model i_alu_host_model (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    // ==========================================================
    // Bus access and comparison helpers
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        i_alu_host_model.xfer(1'b1, a, d, r, last_err);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        i_alu_host_model.xfer(1'b0, a, 32'h00000000, r, last_err);
    endtask : rd
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    task automatic op_check(input logic [4:0] op, input logic [7:0] a, input logic [7:0] b,
        input logic [15:0] pr, input logic [5:0] flg, input logic [7:0] ca,
        input logic [31:0] ev, input logic [5:0] ef);
        wr(ADDR_FLAGS, {26'h0000000, flg});
        wr(ADDR_OPA, {24'h000000, a});
        wr(ADDR_OPB, {24'h000000, b});
        wr(ADDR_PAIR, {16'h0000, pr});
        wr(ADDR_CTRL, {27'h0000000, op});
        rd(ca, v);
        check(v, ev, "value");
        rd(ADDR_FLAGS, v);
        check(v, {26'h0000000, ef}, "flags");
    endtask : op_check
    // ==========================================================
    // Scenarios
    task automatic test_reset();
        for (int i = 0; i < 8; i++) begin
            rd(8'(4 * i), v);
            check(v, 32'h00000000, "reset value");
        end
    endtask : test_reset
    task automatic test_add();
        op_check(OP_ADD, 8'h7F, 8'h01, 16'h0000, 6'h00, ADDR_OPA, 32'h80, 6'h2C);
        op_check(OP_ADC, 8'hFF, 8'h00, 16'h0000, 6'h11, ADDR_OPA, 32'h00, 6'h33);
    endtask : test_add
    task automatic test_sub();
        op_check(OP_SUB, 8'h10, 8'h10, 16'h0000, 6'h3F, ADDR_OPA, 32'h00, 6'h12);
        op_check(OP_SUB_CARRY, 8'h00, 8'h00, 16'h0000, 6'h01, ADDR_OPA, 32'hFF, 6'h25);
        op_check(OP_SUB_K, 8'h80, 8'h01, 16'h0000, 6'h00, ADDR_OPA, 32'h7F, 6'h28);
        op_check(OP_SUB_CARRY_K, 8'h05, 8'h04, 16'h0000, 6'h01, ADDR_OPA, 32'h00, 6'h02);
    endtask : test_sub
    task automatic test_pair();
        op_check(OP_PAIR_SUM, 8'h00, 8'h01, 16'h7FFF, 6'h20, ADDR_PAIR, 32'h8000, 6'h2C);
        op_check(OP_PAIR_SUM, 8'h00, 8'h01, 16'hFFFF, 6'h00, ADDR_PAIR, 32'h0000, 6'h03);
        op_check(OP_PAIR_DIFF, 8'h00, 8'h01, 16'h0000, 6'h20, ADDR_PAIR, 32'hFFFF, 6'h35);
        op_check(OP_PAIR_DIFF, 8'h00, 8'h01, 16'h8000, 6'h00, ADDR_PAIR, 32'h7FFF, 6'h18);
    endtask : test_pair
    task automatic test_logic();
        op_check(OP_AND, 8'hF0, 8'h0F, 16'h0000, 6'h3F, ADDR_OPA, 32'h00, 6'h33);
        op_check(OP_AND_K, 8'hF0, 8'hF0, 16'h0000, 6'h3F, ADDR_OPA, 32'hF0, 6'h35);
        op_check(OP_OR, 8'hF0, 8'h0F, 16'h0000, 6'h3F, ADDR_OPA, 32'hFF, 6'h35);
        op_check(OP_OR_K, 8'hF0, 8'h00, 16'h0000, 6'h3F, ADDR_OPA, 32'hF0, 6'h35);
        op_check(OP_XOR, 8'hF0, 8'hF0, 16'h0000, 6'h3F, ADDR_OPA, 32'h00, 6'h33);
        op_check(OP_SET_MASK, 8'hF0, 8'h01, 16'h0000, 6'h00, ADDR_OPA, 32'hF1, 6'h04);
        op_check(OP_CLR_MASK, 8'hF0, 8'h10, 16'h0000, 6'h3F, ADDR_OPA, 32'hE0, 6'h35);
        op_check(OP_CLR_MASK, 8'hF0, 8'hF0, 16'h0000, 6'h00, ADDR_OPA, 32'h00, 6'h02);
        op_check(OP_TEST, 8'hF0, 8'h00, 16'h0000, 6'h3F, ADDR_OPA, 32'hF0, 6'h35);
        op_check(OP_TEST, 8'h00, 8'h55, 16'h0000, 6'h3F, ADDR_RESULT, 32'h00, 6'h33);
    endtask : test_logic
    task automatic test_product();
        op_check(OP_PROD_U, 8'h80, 8'hFF, 16'h0000, 6'h3C, ADDR_PRODUCT, 32'h7F80, 6'h3C);
        op_check(OP_PROD_S, 8'h80, 8'hFF, 16'h0000, 6'h3C, ADDR_PRODUCT, 32'h0080, 6'h3C);
        op_check(OP_PROD_SU, 8'h80, 8'hFF, 16'h0000, 6'h3C, ADDR_PRODUCT, 32'h8080, 6'h3D);
        op_check(OP_PROD_U, 8'h00, 8'hFF, 16'h0000, 6'h01, ADDR_PRODUCT, 32'h0000, 6'h02);
        op_check(OP_FRAC_U, 8'h80, 8'hFF, 16'h0000, 6'h3C, ADDR_PRODUCT, 32'hFF00, 6'h3C);
        op_check(OP_FRAC_S, 8'h80, 8'hFF, 16'h0000, 6'h3C, ADDR_PRODUCT, 32'h0100, 6'h3C);
        op_check(OP_FRAC_SU, 8'h80, 8'hFF, 16'h0000, 6'h3C, ADDR_PRODUCT, 32'h0100, 6'h3D);
    endtask : test_product
    task automatic test_refuse();
        rd(8'h20, v);
        check({31'h00000000, last_err}, 32'h00000001, "unmapped error");
        check(v, 32'h00000000, "unmapped data");
        wr(ADDR_OPA, 32'h00000033);
        check({31'h00000000, last_err}, 32'h00000000, "accepted write error");
        wr(ADDR_CTRL, 32'h00000016);
        check({31'h00000000, last_err}, 32'h00000001, "bad opcode error");
        rd(ADDR_OPA, v);
        check(v, 32'h00000033, "refused op left operand");
        rd(ADDR_STATUS, v);
        check(v, 32'h00001B00, "completed operation count");
    endtask : test_refuse
    // ==========================================================
    // Verdict, clock, watchdog and main sequence
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        $display("Error at %0t: watchdog expired", $time);
        tally_and_finish();
    end
    initial begin
        presetn = 1'b0;
        mismatches = 0;
        tests_run = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_add();
        test_sub();
        test_pair();
        test_logic();
        test_product();
        test_refuse();
        tally_and_finish();
    end
endmodule : tb_eight_bit_alu_datapath
`default_nettype wire
